// ==== hdl/febr_defines.vh ====
// Register offsets, field positions and reset values of the feature/branch register bank
`ifndef FEBR_DEFINES_VH
`define FEBR_DEFINES_VH

// Register offsets on the 12-bit register port
`define FEBR_ADDR_THERM_CTL 12'h19d
`define FEBR_ADDR_FEATURE 12'h1a0
`define FEBR_ADDR_BRANCH_TOS 12'h1c9
`define FEBR_ADDR_DEBUG_CTL 12'h1d9
`define FEBR_ADDR_EXC_SOURCE 12'h1dd
`define FEBR_ADDR_EXC_TARGET 12'h1de

// Feature-enable register bit positions
`define FEBR_FEAT_AUTO_THERM 3
`define FEBR_FEAT_FREQ_THERM 13
`define FEBR_FEAT_STEPPING 16
`define FEBR_FEAT_MONITOR 18
`define FEBR_FEAT_LEAF_LIMIT 22
`define FEBR_FEAT_XD_OFF 34

// Writable bits of the feature-enable register; all others read zero
`define FEBR_FEAT_WRITE_MASK 64'h0000_0004_0045_2008

// Thermal control register fields
`define FEBR_THERM_SETTING_MSB 15
`define FEBR_THERM_MODE_BIT 16

// Branch stack index width and debug control branch-record enable
`define FEBR_TOS_WIDTH 4
`define FEBR_DBG_RECORD_BIT 0

// Reported leaf ceiling when the leaf limit is set
`define FEBR_LEAF_CAP 32'h0000_0003

// Reset values
`define FEBR_RST_FEATURE 64'h0000_0000_0000_0000
`define FEBR_RST_THERM_CTL 17'h0_0000
`define FEBR_RST_TOS 4'h0
`define FEBR_RST_DEBUG_CTL 64'h0000_0000_0000_0000
`define FEBR_RST_POINTER 64'h0000_0000_0000_0000

`endif

// ==== hdl/febr_ler.v ====
// Last-branch and last-exception pointer capture for the feature/branch register bank
`timescale 1ns/1ps
`include "febr_defines.vh"

module febr_ler #(
    parameter ADDR_WIDTH = 64
) (
    input wire clock,
    input wire reset_n,
    input wire record_enable,
    input wire branch_valid,
    input wire [ADDR_WIDTH-1:0] branch_from,
    input wire [ADDR_WIDTH-1:0] branch_to,
    input wire exception,
    output reg [ADDR_WIDTH-1:0] exc_source,
    output reg [ADDR_WIDTH-1:0] exc_target
);

    // Most recent branch seen while recording is on
    reg [ADDR_WIDTH-1:0] last_from;
    reg [ADDR_WIDTH-1:0] last_to;

    // Track latest branch; freeze it into the exception record on an event
    always @(posedge clock) begin
        if (!reset_n) begin
            last_from <= `FEBR_RST_POINTER;
            last_to <= `FEBR_RST_POINTER;
            exc_source <= `FEBR_RST_POINTER;
            exc_target <= `FEBR_RST_POINTER;
        end else begin
            // Branch retiring alongside the event belongs before it
            if (branch_valid && record_enable) begin
                last_from <= branch_from;
                last_to <= branch_to;
            end
            if (exception) begin
                if (branch_valid && record_enable) begin
                    exc_source <= branch_from; // see R11
                    exc_target <= branch_to; // see R12
                end else begin
                    exc_source <= last_from; // see R11
                    exc_target <= last_to; // see R12
                end
            end
        end
    end

endmodule

// ==== hdl/febr_top.v ====
// Feature-enable upper fields, thermal control and branch/exception recording registers
`timescale 1ns/1ps
`include "febr_defines.vh"

// Contract
// R1: Bit 13 plus hot engages frequency thermal control; here only with bit 3 and mode bit 16 also set
// R2: Bit 13 clear keeps ratio and voltage
// R3: Firmware leaves bit 13 when unsupported
// R4: Software never disables both thermal mechanisms
// R5: Bit 16 enables dynamic frequency stepping
// R6: Bit 18 enables the monitor state machine
// R7: Bit 22 caps reported leaf at three
// R8: Bit 34 disables execute-disable protection
// R9: Stack top index held in bits 3:0
// R10: Debug control register is read-write
// R11: Exception source holds last branch address
// R12: Exception target holds last branch target
// R13: Mode bit picks duty or frequency control
// R14: Reserved feature bits read zero, ignore writes
module febr_top #(
    parameter ADDR_WIDTH = 12,
    parameter DATA_WIDTH = 64,
    parameter LEAF_WIDTH = 32,
    parameter SETTING_WIDTH = 16
) (
    input wire CLOCK,
    input wire RESET_N,
    input wire [ADDR_WIDTH-1:0] REG_ADDR,
    input wire [DATA_WIDTH-1:0] REG_WDATA,
    input wire REG_WRITE,
    input wire REG_READ,
    output reg [DATA_WIDTH-1:0] REG_RDATA,
    input wire THERMAL_HOT,
    input wire [SETTING_WIDTH-1:0] NOMINAL_SETTING,
    output reg [SETTING_WIDTH-1:0] OPERATING_SETTING,
    output reg FREQ_THERMAL_ACTIVE,
    output reg DUTY_THERMAL_ACTIVE,
    output wire STEPPING_ENABLE,
    output wire MONITOR_FSM_ENABLE,
    output wire EXEC_DISABLE_OFF,
    output wire BRANCH_RECORD_ENABLE,
    input wire [LEAF_WIDTH-1:0] NATIVE_MAX_LEAF,
    output reg [LEAF_WIDTH-1:0] REPORTED_MAX_LEAF,
    input wire BRANCH_VALID,
    input wire [DATA_WIDTH-1:0] BRANCH_FROM,
    input wire [DATA_WIDTH-1:0] BRANCH_TO,
    input wire EXCEPTION_EVENT
);

    // Stored register contents
    reg [DATA_WIDTH-1:0] feature_enable_upper; // Only writable bits ever become one
    reg [16:0] thermal_control_reg; // Setting in 15:0, mode select in 16
    reg [`FEBR_TOS_WIDTH-1:0] branch_stack_top_index; // Most recent record slot
    reg [DATA_WIDTH-1:0] debug_feature_control; // Debug feature controls

    // Exception record pointers from the capture block
    wire [DATA_WIDTH-1:0] exception_branch_source;
    wire [DATA_WIDTH-1:0] exception_branch_target;

    // Thermal sensor synchroniser, first stage read only by the second
    reg hot_meta;
    reg hot_sync;

    // Next values
    reg [DATA_WIDTH-1:0] next_rdata;
    reg [`FEBR_TOS_WIDTH-1:0] next_tos;

    // Decoded controls
    wire auto_therm_enable;
    wire freq_therm_enable;
    wire thermal_mode_select;
    wire leaf_limit;

    // Address match helper shared by write and read decode
    function hit;
        input [ADDR_WIDTH-1:0] addr;
        input [ADDR_WIDTH-1:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // Field views of the stored registers
    assign auto_therm_enable = feature_enable_upper[`FEBR_FEAT_AUTO_THERM];
    assign freq_therm_enable = feature_enable_upper[`FEBR_FEAT_FREQ_THERM];
    assign thermal_mode_select = thermal_control_reg[`FEBR_THERM_MODE_BIT];
    assign leaf_limit = feature_enable_upper[`FEBR_FEAT_LEAF_LIMIT];

    // Control levels straight from feature and debug bits
    assign STEPPING_ENABLE = feature_enable_upper[`FEBR_FEAT_STEPPING]; // see R5
    assign MONITOR_FSM_ENABLE = feature_enable_upper[`FEBR_FEAT_MONITOR]; // see R6
    assign EXEC_DISABLE_OFF = feature_enable_upper[`FEBR_FEAT_XD_OFF]; // see R8
    assign BRANCH_RECORD_ENABLE = debug_feature_control[`FEBR_DBG_RECORD_BIT];

    // Two-stage synchroniser for the asynchronous thermal sensor pin
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            hot_meta <= 1'b0;
            hot_sync <= 1'b0;
        end else begin
            hot_meta <= THERMAL_HOT;
            hot_sync <= hot_meta;
        end
    end

    // Feature-enable register: only documented control bits are stored
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            feature_enable_upper <= `FEBR_RST_FEATURE;
        end else if (REG_WRITE && hit(REG_ADDR, `FEBR_ADDR_FEATURE)) begin
            // Reserved positions masked away on write
            feature_enable_upper <= REG_WDATA & `FEBR_FEAT_WRITE_MASK; // see R14 R5 R6 R7 R8
        end
    end

    // Thermal control register: setting and automatic mode select
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            thermal_control_reg <= `FEBR_RST_THERM_CTL;
        end else if (REG_WRITE && hit(REG_ADDR, `FEBR_ADDR_THERM_CTL)) begin
            thermal_control_reg <= REG_WDATA[16:0];
        end
    end

    // Debug control register, fully read-write
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            debug_feature_control <= `FEBR_RST_DEBUG_CTL;
        end else if (REG_WRITE && hit(REG_ADDR, `FEBR_ADDR_DEBUG_CTL)) begin
            debug_feature_control <= REG_WDATA; // see R10
        end
    end

    // Stack top next value: a recorded branch wins over a software write
    always @* begin
        next_tos = branch_stack_top_index;
        if (REG_WRITE && hit(REG_ADDR, `FEBR_ADDR_BRANCH_TOS)) begin
            // Software places the index directly
            next_tos = REG_WDATA[`FEBR_TOS_WIDTH-1:0]; // see R9
        end
        if (BRANCH_VALID && BRANCH_RECORD_ENABLE) begin
            // Advance to the slot that now holds the newest record
            next_tos = branch_stack_top_index + 4'h1; // see R9
        end
    end

    // Stack top index register
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            branch_stack_top_index <= `FEBR_RST_TOS;
        end else begin
            branch_stack_top_index <= next_tos;
        end
    end

    // Exception record capture
    febr_ler #(
        .ADDR_WIDTH(DATA_WIDTH)
    ) u_ler (
        .clock(CLOCK),
        .reset_n(RESET_N),
        .record_enable(BRANCH_RECORD_ENABLE),
        .branch_valid(BRANCH_VALID),
        .branch_from(BRANCH_FROM),
        .branch_to(BRANCH_TO),
        .exception(EXCEPTION_EVENT),
        .exc_source(exception_branch_source),
        .exc_target(exception_branch_target)
    );

    // Thermal response, registered one cycle after the synchronised sensor
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            FREQ_THERMAL_ACTIVE <= 1'b0;
            DUTY_THERMAL_ACTIVE <= 1'b0;
            OPERATING_SETTING <= {SETTING_WIDTH{1'b0}};
        end else begin
            // Duty-cycle modulation only with auto enable and mode zero
            DUTY_THERMAL_ACTIVE <= hot_sync && auto_therm_enable && !thermal_mode_select; // see R13
            if (hot_sync && freq_therm_enable && auto_therm_enable && thermal_mode_select) begin
                // Drop to the last written ratio and voltage setting
                FREQ_THERMAL_ACTIVE <= 1'b1; // see R1 R13
                OPERATING_SETTING <= thermal_control_reg[`FEBR_THERM_SETTING_MSB:0]; // see R1
            end else begin
                // No frequency thermal action: nominal setting passes unchanged
                FREQ_THERMAL_ACTIVE <= 1'b0; // see R2
                OPERATING_SETTING <= NOMINAL_SETTING; // see R2
            end
        end
    end

    // Reported identification leaf ceiling
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            REPORTED_MAX_LEAF <= {LEAF_WIDTH{1'b0}};
        end else if (leaf_limit && (NATIVE_MAX_LEAF > `FEBR_LEAF_CAP)) begin
            // Hide every leaf above the cap
            REPORTED_MAX_LEAF <= `FEBR_LEAF_CAP; // see R7
        end else begin
            REPORTED_MAX_LEAF <= NATIVE_MAX_LEAF;
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        next_rdata = {DATA_WIDTH{1'b0}};
        if (hit(REG_ADDR, `FEBR_ADDR_FEATURE)) begin
            next_rdata = feature_enable_upper; // see R14
        end else if (hit(REG_ADDR, `FEBR_ADDR_THERM_CTL)) begin
            next_rdata = {47'h0, thermal_control_reg};
        end else if (hit(REG_ADDR, `FEBR_ADDR_BRANCH_TOS)) begin
            next_rdata = {60'h0, branch_stack_top_index}; // see R9
        end else if (hit(REG_ADDR, `FEBR_ADDR_DEBUG_CTL)) begin
            next_rdata = debug_feature_control; // see R10
        end else if (hit(REG_ADDR, `FEBR_ADDR_EXC_SOURCE)) begin
            next_rdata = exception_branch_source; // see R11
        end else if (hit(REG_ADDR, `FEBR_ADDR_EXC_TARGET)) begin
            next_rdata = exception_branch_target; // see R12
        end
    end

    // Read data stand only in the cycle after the read strobe
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            REG_RDATA <= {DATA_WIDTH{1'b0}};
        end else if (REG_READ) begin
            REG_RDATA <= next_rdata;
        end else begin
            REG_RDATA <= {DATA_WIDTH{1'b0}};
        end
    end

endmodule

// ==== test/febr_chk.sv ====
// Port-level checks for the feature/branch register bank
`timescale 1ns/1ps
`include "febr_defines.vh"
module febr_chk (
    input wire CLOCK,
    input wire RESET_N,
    input wire [11:0] REG_ADDR,
    input wire [63:0] REG_WDATA,
    input wire REG_WRITE,
    input wire REG_READ,
    input wire [63:0] REG_RDATA,
    input wire THERMAL_HOT,
    input wire [15:0] NOMINAL_SETTING,
    input wire [15:0] OPERATING_SETTING,
    input wire FREQ_THERMAL_ACTIVE,
    input wire DUTY_THERMAL_ACTIVE,
    input wire STEPPING_ENABLE,
    input wire MONITOR_FSM_ENABLE,
    input wire BRANCH_RECORD_ENABLE,
    input wire [31:0] NATIVE_MAX_LEAF,
    input wire [31:0] REPORTED_MAX_LEAF,
    input wire BRANCH_VALID,
    input wire [63:0] BRANCH_FROM,
    input wire EXCEPTION_EVENT
);
    reg [63:0] last_from; // Last recorded branch source
    reg [63:0] exc_from; // Source frozen at the last exception
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // Shadow of the exception source; a same-cycle branch counts first
    always @(posedge CLOCK) begin
        if (!RESET_N) begin
            last_from <= 64'h0;
            exc_from <= 64'h0;
        end else begin
            if (BRANCH_VALID && BRANCH_RECORD_ENABLE) begin
                last_from <= BRANCH_FROM;
            end
            if (EXCEPTION_EVENT) begin
                exc_from <= (BRANCH_VALID && BRANCH_RECORD_ENABLE) ? BRANCH_FROM : last_from;
            end
        end
    end
    a_rdata_idle_zero: assert property (!$past(REG_READ) |-> REG_RDATA == 64'h0)
        else $error("read data not zero outside a read answer");
    a_stepping_follows_write: assert property (REG_WRITE && REG_ADDR == `FEBR_ADDR_FEATURE |=>
        STEPPING_ENABLE == $past(REG_WDATA[16])) else $error("stepping enable differs from written bit");
    a_monitor_holds: assert property ($past(RESET_N) && !$past(REG_WRITE) |-> $stable(MONITOR_FSM_ENABLE))
        else $error("monitor enable moved without a write");
    a_leaf_capped: assert property ($past(RESET_N) && REPORTED_MAX_LEAF != $past(NATIVE_MAX_LEAF) |->
        REPORTED_MAX_LEAF == 32'h3 && $past(NATIVE_MAX_LEAF) > 32'h3) else $error("reported leaf wrong");
    a_nominal_kept: assert property ($past(RESET_N) && !FREQ_THERMAL_ACTIVE |->
        OPERATING_SETTING == $past(NOMINAL_SETTING)) else $error("setting moved without frequency control");
    a_modes_exclusive: assert property (!(FREQ_THERMAL_ACTIVE && DUTY_THERMAL_ACTIVE))
        else $error("both thermal modes engaged");
    a_freq_needs_hot: assert property (FREQ_THERMAL_ACTIVE |-> $past(THERMAL_HOT, 3))
        else $error("frequency control without hot sensor");
    a_exc_source_read: assert property (REG_READ && REG_ADDR == `FEBR_ADDR_EXC_SOURCE |=>
        REG_RDATA == $past(exc_from)) else $error("exception source read wrong");
    c_freq: cover property (FREQ_THERMAL_ACTIVE);
    c_duty: cover property (DUTY_THERMAL_ACTIVE);
    c_cap: cover property (REPORTED_MAX_LEAF == 32'h3);
endmodule
bind febr_top febr_chk u_chk (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ),
    .REG_RDATA(REG_RDATA),
    .THERMAL_HOT(THERMAL_HOT),
    .NOMINAL_SETTING(NOMINAL_SETTING),
    .OPERATING_SETTING(OPERATING_SETTING),
    .FREQ_THERMAL_ACTIVE(FREQ_THERMAL_ACTIVE),
    .DUTY_THERMAL_ACTIVE(DUTY_THERMAL_ACTIVE),
    .STEPPING_ENABLE(STEPPING_ENABLE),
    .MONITOR_FSM_ENABLE(MONITOR_FSM_ENABLE),
    .BRANCH_RECORD_ENABLE(BRANCH_RECORD_ENABLE),
    .NATIVE_MAX_LEAF(NATIVE_MAX_LEAF),
    .REPORTED_MAX_LEAF(REPORTED_MAX_LEAF),
    .BRANCH_VALID(BRANCH_VALID),
    .BRANCH_FROM(BRANCH_FROM),
    .EXCEPTION_EVENT(EXCEPTION_EVENT)
);

// ==== test/tb_top.sv ====
// Self-checking bench for the feature/branch register bank
`timescale 1ns/1ps
`include "febr_defines.vh"
module tb_top;
    reg CLOCK = 1'b0;
    reg RESET_N = 1'b0;
    reg [11:0] REG_ADDR = 12'h000;
    reg [63:0] REG_WDATA = 64'h0;
    reg REG_WRITE = 1'b0;
    reg REG_READ = 1'b0;
    reg THERMAL_HOT = 1'b0;
    reg [15:0] NOMINAL_SETTING = 16'h1234;
    reg [31:0] NATIVE_MAX_LEAF = 32'h9;
    reg BRANCH_VALID = 1'b0;
    reg [63:0] BRANCH_FROM = 64'h0;
    reg [63:0] BRANCH_TO = 64'h0;
    reg EXCEPTION_EVENT = 1'b0;
    wire [63:0] REG_RDATA;
    wire [15:0] OPERATING_SETTING;
    wire [31:0] REPORTED_MAX_LEAF;
    wire FREQ_THERMAL_ACTIVE, DUTY_THERMAL_ACTIVE, STEPPING_ENABLE;
    wire MONITOR_FSM_ENABLE, EXEC_DISABLE_OFF, BRANCH_RECORD_ENABLE;
    integer failures = 0;
    integer total_checks = 0;
    integer cycles = 0;
    febr_top u_dut (
        .CLOCK(CLOCK),
        .RESET_N(RESET_N),
        .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA),
        .REG_WRITE(REG_WRITE),
        .REG_READ(REG_READ),
        .REG_RDATA(REG_RDATA),
        .THERMAL_HOT(THERMAL_HOT),
        .NOMINAL_SETTING(NOMINAL_SETTING),
        .OPERATING_SETTING(OPERATING_SETTING),
        .FREQ_THERMAL_ACTIVE(FREQ_THERMAL_ACTIVE),
        .DUTY_THERMAL_ACTIVE(DUTY_THERMAL_ACTIVE),
        .STEPPING_ENABLE(STEPPING_ENABLE),
        .MONITOR_FSM_ENABLE(MONITOR_FSM_ENABLE),
        .EXEC_DISABLE_OFF(EXEC_DISABLE_OFF),
        .BRANCH_RECORD_ENABLE(BRANCH_RECORD_ENABLE),
        .NATIVE_MAX_LEAF(NATIVE_MAX_LEAF),
        .REPORTED_MAX_LEAF(REPORTED_MAX_LEAF),
        .BRANCH_VALID(BRANCH_VALID),
        .BRANCH_FROM(BRANCH_FROM),
        .BRANCH_TO(BRANCH_TO),
        .EXCEPTION_EVENT(EXCEPTION_EVENT)
    );
    always #5 CLOCK = ~CLOCK;
    // Hang guard
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    task cmp(input string n, input logic [63:0] e, input logic [63:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [11:0] a, input logic [63:0] d);
        @(posedge CLOCK);
        REG_WRITE <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLOCK);
        REG_WRITE <= 1'b0;
        #1;
    endtask
    task rd(input logic [11:0] a, input logic [63:0] e, input string n);
        @(posedge CLOCK);
        REG_READ <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_READ <= 1'b0;
        #1;
        cmp(n, e, REG_RDATA);
    endtask
    task step(input integer n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    task brn(input logic v, input logic x, input logic [63:0] f, input logic [63:0] t);
        @(posedge CLOCK);
        BRANCH_VALID <= v;
        EXCEPTION_EVENT <= x;
        BRANCH_FROM <= f;
        BRANCH_TO <= t;
        @(posedge CLOCK);
        BRANCH_VALID <= 1'b0;
        EXCEPTION_EVENT <= 1'b0;
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge CLOCK);
        RESET_N <= 1'b1;
        rd(`FEBR_ADDR_FEATURE, 64'h0, "feature reset");
        rd(`FEBR_ADDR_BRANCH_TOS, 64'h0, "tos reset");
        wr(12'h123, 64'hffff);
        rd(12'h123, 64'h0, "unmapped");
        $display("test reset done");
        wr(`FEBR_ADDR_FEATURE, {64{1'b1}});
        cmp("stepping", 64'h1, STEPPING_ENABLE);
        cmp("monitor", 64'h1, MONITOR_FSM_ENABLE);
        cmp("xd off", 64'h1, EXEC_DISABLE_OFF);
        rd(`FEBR_ADDR_FEATURE, 64'h0000_0004_0045_2008, "feature mask");
        cmp("leaf cap", 64'h3, REPORTED_MAX_LEAF);
        @(posedge CLOCK);
        NATIVE_MAX_LEAF <= 32'h2;
        step(2);
        cmp("leaf low", 64'h2, REPORTED_MAX_LEAF);
        @(posedge CLOCK);
        NATIVE_MAX_LEAF <= 32'h9;
        wr(`FEBR_ADDR_FEATURE, 64'h8);
        cmp("stepping off", 64'h0, STEPPING_ENABLE);
        cmp("monitor off", 64'h0, MONITOR_FSM_ENABLE);
        cmp("xd on", 64'h0, EXEC_DISABLE_OFF);
        step(1);
        cmp("leaf native", 64'h9, REPORTED_MAX_LEAF);
        $display("test feature done");
        wr(`FEBR_ADDR_THERM_CTL, 64'h1_abcd);
        wr(`FEBR_ADDR_FEATURE, 64'h2008);
        @(posedge CLOCK);
        THERMAL_HOT <= 1'b1;
        step(4);
        cmp("freq on", 64'h1, FREQ_THERMAL_ACTIVE);
        cmp("thermal setting", 64'habcd, OPERATING_SETTING);
        cmp("duty off", 64'h0, DUTY_THERMAL_ACTIVE);
        wr(`FEBR_ADDR_FEATURE, 64'h8);
        step(1);
        cmp("freq off", 64'h0, FREQ_THERMAL_ACTIVE);
        cmp("nominal kept", 64'h1234, OPERATING_SETTING);
        wr(`FEBR_ADDR_THERM_CTL, 64'h0);
        step(1);
        cmp("duty on", 64'h1, DUTY_THERMAL_ACTIVE);
        wr(`FEBR_ADDR_FEATURE, 64'h2000);
        step(1);
        cmp("auto off", 64'h0, DUTY_THERMAL_ACTIVE | FREQ_THERMAL_ACTIVE);
        @(posedge CLOCK);
        THERMAL_HOT <= 1'b0;
        $display("test thermal done");
        wr(`FEBR_ADDR_DEBUG_CTL, 64'h1);
        cmp("record on", 64'h1, BRANCH_RECORD_ENABLE);
        rd(`FEBR_ADDR_DEBUG_CTL, 64'h1, "debug");
        wr(`FEBR_ADDR_BRANCH_TOS, 64'hfff);
        rd(`FEBR_ADDR_BRANCH_TOS, 64'hf, "tos width");
        brn(1'b1, 1'b0, 64'h100, 64'h200);
        rd(`FEBR_ADDR_BRANCH_TOS, 64'h0, "tos wrap");
        brn(1'b1, 1'b1, 64'h300, 64'h400);
        brn(1'b1, 1'b0, 64'h500, 64'h600);
        rd(`FEBR_ADDR_EXC_SOURCE, 64'h300, "exc source");
        rd(`FEBR_ADDR_EXC_TARGET, 64'h400, "exc target");
        wr(`FEBR_ADDR_EXC_SOURCE, 64'hdead);
        rd(`FEBR_ADDR_EXC_SOURCE, 64'h300, "source read only");
        rd(`FEBR_ADDR_BRANCH_TOS, 64'h2, "tos count");
        brn(1'b0, 1'b1, 64'h0, 64'h0);
        rd(`FEBR_ADDR_EXC_TARGET, 64'h600, "exc target later");
        wr(`FEBR_ADDR_DEBUG_CTL, 64'h0);
        cmp("record off", 64'h0, BRANCH_RECORD_ENABLE);
        brn(1'b1, 1'b1, 64'h700, 64'h800);
        rd(`FEBR_ADDR_EXC_SOURCE, 64'h500, "source unrecorded");
        rd(`FEBR_ADDR_BRANCH_TOS, 64'h2, "tos held");
        $display("test branch done");
        end_of_test;
    end
endmodule
